//--- rxeq_adapt.sv
// eq selection engine for one connector-facing receiver lane
// assumes eye_score comes from same-clock logic; insert and chan_long already synchronised
module rxeq_adapt
   import rxeq_pkg::*;
#(
   parameter int unsigned FAST_CYC  = rxeq_pkg::FAST_EVAL_CYC,
   parameter int unsigned DWELL_CYC = rxeq_pkg::SWEEP_DWELL_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  active,
   input  wire rxeq_pkg::rxeq_cmode_e mode,
   input  wire rxeq_pkg::rxeq_idx_t   short_idx,
   input  wire rxeq_pkg::rxeq_idx_t   long_idx,
   input  wire logic                  insert,
   input  wire logic                  chan_long,
   input  wire logic [7:0]            eye_score,
   output rxeq_pkg::rxeq_idx_t        idx,
   output logic                       busy
);
   typedef enum logic [1:0] {ST_IDLE, ST_FAST, ST_SWEEP} rxeq_ad_e;
   typedef struct packed {
      rxeq_ad_e    st;
      logic [CNT_W-1:0] cnt;
      rxeq_idx_t   step;
      rxeq_idx_t   best_idx;
      logic [7:0]  best_score;
      logic        use_long;
      logic        ins_d;
      rxeq_cmode_e mode_d;
      rxeq_idx_t   idx;
      logic        busy;
   } rxeq_ad_s;

   rxeq_ad_s ad_r;
   rxeq_ad_s ad_nxt;
   logic     start;

   always_comb begin
      ad_nxt        = ad_r;
      ad_nxt.ins_d  = insert;
      ad_nxt.mode_d = mode;
      start = active && ((insert && !ad_r.ins_d) || (mode != ad_r.mode_d)); // R13
      case (ad_r.st)
         ST_IDLE: begin
            ad_nxt.cnt = '0;
            if (start && mode == CMODE_SHORT_LONG) begin
               ad_nxt.st = ST_FAST;
            end else if (start && mode == CMODE_SWEEP) begin
               ad_nxt.st   = ST_SWEEP; // R13
               ad_nxt.step = '0;
            end
         end
         ST_FAST: begin
            ad_nxt.cnt = ad_r.cnt + 1'b1;
            if (ad_r.cnt == CNT_W'(FAST_CYC - 1)) begin // R16
               ad_nxt.use_long = chan_long; // R12
               ad_nxt.st       = ST_IDLE;
            end
         end
         ST_SWEEP: begin
            ad_nxt.cnt = ad_r.cnt + 1'b1;
            if (ad_r.cnt == CNT_W'(DWELL_CYC - 1)) begin // R17
               ad_nxt.cnt = '0;
               if (ad_r.step == '0 || eye_score > ad_r.best_score) begin
                  ad_nxt.best_idx   = ad_r.step;
                  ad_nxt.best_score = eye_score;
               end
               if (ad_r.step == 4'hF) begin
                  ad_nxt.st = ST_IDLE;
               end else begin
                  ad_nxt.step = ad_r.step + 1'b1;
               end
            end
         end
         default: begin
            ad_nxt.st = ST_IDLE;
         end
      endcase
      // abort on disable or fixed selection
      if (!active || mode == CMODE_FIXED || mode == CMODE_RSVD) begin
         ad_nxt.st = ST_IDLE;
      end
      case (mode)
         CMODE_SHORT_LONG: begin
            ad_nxt.idx = (ad_nxt.st == ST_IDLE && ad_nxt.use_long) ? long_idx : short_idx; // R12
         end
         CMODE_SWEEP: begin
            ad_nxt.idx = (ad_nxt.st == ST_SWEEP) ? ad_nxt.step : ad_nxt.best_idx;
         end
         default: begin
            ad_nxt.idx = short_idx; // R11
         end
      endcase
      ad_nxt.busy = (ad_nxt.st != ST_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_r        <= '0;
         ad_r.st     <= ST_IDLE;
         ad_r.mode_d <= CMODE_RST;
      end else begin
         ad_r <= ad_nxt;
      end
   end

   assign idx  = ad_r.idx;
   assign busy = ad_r.busy;
endmodule

//--- rxeq_board.sv
// board model: strap resistors and receptacle eye quality
// assumes strap settings given as eq index, pull_en from the device
module rxeq_board
   import rxeq_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                pull_en,
   input  wire rxeq_pkg::rxeq_idx_t conn_set,
   input  wire rxeq_pkg::rxeq_idx_t host_set,
   input  wire rxeq_pkg::rxeq_idx_t peak_a,
   input  wire rxeq_pkg::rxeq_idx_t peak_b,
   input  wire rxeq_pkg::rxeq_idx_t idx_a,
   input  wire rxeq_pkg::rxeq_idx_t idx_b,
   output rxeq_pkg::rxeq_lvl_t      conn_hi,
   output rxeq_pkg::rxeq_lvl_t      conn_lo,
   output rxeq_pkg::rxeq_lvl_t      host_hi,
   output rxeq_pkg::rxeq_lvl_t      host_lo,
   output logic [7:0]               eye_a,
   output logic [7:0]               eye_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog_r = 1'b0;
   always @(posedge clk) tog_r <= !tog_r;
   // open pin wanders once internal pulls are isolated
   function automatic rxeq_lvl_t lvl(input rxeq_lvl_t c, input logic pe, input logic t);
      if (c == LVL_OPEN && !pe)
         return t ? LVL_GND_WEAK : LVL_VCC;
      return c;
   endfunction
   function automatic logic [7:0] eye(input rxeq_idx_t i, input rxeq_idx_t p);
      rxeq_idx_t d;
      d = (i > p) ? i - p : p - i;
      return 8'hFF - {d, 4'h0};
   endfunction
   assign conn_hi = lvl(conn_set[3:2], pull_en, tog_r);
   assign conn_lo = lvl(conn_set[1:0], pull_en, tog_r);
   assign host_hi = lvl(host_set[3:2], pull_en, tog_r);
   assign host_lo = lvl(host_set[1:0], pull_en, tog_r);
   assign eye_a = eye(idx_a, peak_a);
   assign eye_b = eye(idx_b, peak_b);
endmodule

//--- rxeq_pkg.sv
// constants, types and register map for the receiver eq strap/config block
// assumes one 200 MHz system clock and an apb register bus
package rxeq_pkg;
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned FAST_DONE_US    = 60;
   localparam int unsigned FULL_DONE_US    = 400;
   localparam int unsigned DONE_MARGIN_CYC = 8;
   localparam int unsigned EQ_SETTINGS     = 16;
   localparam int unsigned FAST_DONE_CYC   = FAST_DONE_US * CLK_MHZ;
   localparam int unsigned FULL_DONE_CYC   = FULL_DONE_US * CLK_MHZ;
   localparam int unsigned FAST_EVAL_CYC   = FAST_DONE_CYC - DONE_MARGIN_CYC;
   localparam int unsigned SWEEP_DWELL_CYC = (FULL_DONE_CYC - DONE_MARGIN_CYC) / EQ_SETTINGS;
   localparam int unsigned CNT_W           = 17;

   typedef logic [3:0] rxeq_idx_t;
   typedef logic [1:0] rxeq_lvl_t;

   // sensed strap level codes
   localparam rxeq_lvl_t LVL_GND_STRONG = 2'h0;
   localparam rxeq_lvl_t LVL_GND_WEAK   = 2'h1;
   localparam rxeq_lvl_t LVL_OPEN       = 2'h2;
   localparam rxeq_lvl_t LVL_VCC        = 2'h3;

   typedef enum logic [1:0] {CMODE_FIXED, CMODE_SHORT_LONG, CMODE_SWEEP, CMODE_RSVD} rxeq_cmode_e;
   typedef enum logic [3:0] {REG_CTRL, REG_CONN_A, REG_CONN_B, REG_HOST_A, REG_HOST_B,
                             REG_LONG_A, REG_LONG_B, REG_STATUS, REG_APPLIED, REG_NONE} rxeq_reg_e;

   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CONN_A  = 8'h04;
   localparam logic [7:0] OFS_CONN_B  = 8'h08;
   localparam logic [7:0] OFS_HOST_A  = 8'h0C;
   localparam logic [7:0] OFS_HOST_B  = 8'h10;
   localparam logic [7:0] OFS_LONG_A  = 8'h14;
   localparam logic [7:0] OFS_LONG_B  = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1C;
   localparam logic [7:0] OFS_APPLIED = 8'h20;

   localparam int unsigned CTRL_SRC_POS  = 0;
   localparam int unsigned CTRL_MODE_POS = 1;
   localparam logic        SRC_RST       = 1'b0;
   localparam rxeq_cmode_e CMODE_RST     = CMODE_FIXED;
   localparam rxeq_idx_t   IDX_RST       = 4'h0;
   localparam logic        PULL_RST      = 1'b1;
   localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
endpackage

//--- rxeq_strap_cfg.sv
// top of receiver eq configuration: strap capture, apb registers, per-lane eq select
// assumes strap pins arrive as 2-bit sensed level codes from the analog front end
//
// Behaviour
// R1: capture every four-level strap input once just after enable rises.
// R2: after sampling, switch off the internal pull networks on strap pins.
// R3: each strap resolves to 0, R, F or 1; board presents exactly one.
// R4: in strap mode a pin pair picks one of sixteen eq settings.
// R5: index is four times upper pin code plus lower pin code.
// R6: connector and host receiver groups each use their own strap pair.
// R7: every receiver lane has its own eq index control.
// R8: register mode offers the same sixteen indices through four lane registers.
// R9: host-facing receivers use a fixed index only, never adaptive.
// R10: connector receivers offer fixed, short/long adaptive and sweep adaptive modes.
// R11: fixed mode applies one configured index whatever is attached.
// R12: short/long mode classifies the channel and applies one of two indices.
// R13: sweep mode reruns its search on every new insertion. Code ignores an insertion that arrives while a sweep is still running.
// R14: software disables adaptive modes when connector side is wired directly.
// R15: adaptive only on the part nearest the receptacle, never in active cables.
// R16: short/long decision settles within sixty microseconds.
// R17: sweep search finds its best index within four hundred microseconds.
// R18: latched straps hold while enable is high; recapture on next rise only.
module rxeq_strap_cfg
   import rxeq_pkg::*;
#(
   parameter int unsigned ADDR_W    = 8,
   parameter int unsigned FAST_CYC  = rxeq_pkg::FAST_EVAL_CYC,
   parameter int unsigned DWELL_CYC = rxeq_pkg::SWEEP_DWELL_CYC
) (
   input  wire logic                CLK_SYS,
   input  wire logic                RST_N,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [ADDR_W-1:0]   PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic                EN,
   input  wire rxeq_pkg::rxeq_lvl_t CONN_EQ_STRAP_HI,
   input  wire rxeq_pkg::rxeq_lvl_t CONN_EQ_STRAP_LO,
   input  wire rxeq_pkg::rxeq_lvl_t HOST_EQ_STRAP_HI,
   input  wire rxeq_pkg::rxeq_lvl_t HOST_EQ_STRAP_LO,
   input  wire logic                CONN_INSERT,
   input  wire logic                CONN_A_CHAN_LONG,
   input  wire logic                CONN_B_CHAN_LONG,
   input  wire logic [7:0]          CONN_A_EYE_SCORE,
   input  wire logic [7:0]          CONN_B_EYE_SCORE,
   output logic                     STRAP_PULL_EN,
   output rxeq_pkg::rxeq_idx_t      CONN_LANE_A_EQ_INDEX,
   output rxeq_pkg::rxeq_idx_t      CONN_LANE_B_EQ_INDEX,
   output rxeq_pkg::rxeq_idx_t      HOST_LANE_A_EQ_INDEX,
   output rxeq_pkg::rxeq_idx_t      HOST_LANE_B_EQ_INDEX
);
   import rxeq_pkg::*;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        cfg_src;
      rxeq_cmode_e cmode;
      rxeq_idx_t   reg_ca;
      rxeq_idx_t   reg_cb;
      rxeq_idx_t   reg_ha;
      rxeq_idx_t   reg_hb;
      rxeq_idx_t   long_a;
      rxeq_idx_t   long_b;
      rxeq_idx_t   strap_conn;
      rxeq_idx_t   strap_host;
      logic        captured;
      logic        pull_en;
      logic        en_d;
      rxeq_idx_t   out_ca;
      rxeq_idx_t   out_cb;
      rxeq_idx_t   out_ha;
      rxeq_idx_t   out_hb;
   } rxeq_top_s;

   rxeq_top_s   top_r;
   rxeq_top_s   top_nxt;

   logic [11:0] pins_raw;
   logic [11:0] pins_q;
   logic        en_q;
   logic        ins_q;
   logic        long_a_q;
   logic        long_b_q;
   rxeq_lvl_t   c_hi_q;
   rxeq_lvl_t   c_lo_q;
   rxeq_lvl_t   h_hi_q;
   rxeq_lvl_t   h_lo_q;

   logic        en_rise;
   logic        adapt_active;
   rxeq_cmode_e conn_mode;
   rxeq_idx_t   short_a;
   rxeq_idx_t   short_b;
   rxeq_idx_t   ad_idx_a;
   rxeq_idx_t   ad_idx_b;
   logic        ad_busy_a;
   logic        ad_busy_b;
   logic        setup_ph;
   logic        access_ph;
   rxeq_reg_e   sel;
   logic [31:0] rd_word;

   // strap pair to setting index; level codes are already 0..3
   function automatic rxeq_idx_t strap_index(input rxeq_lvl_t hi, input rxeq_lvl_t lo);
      strap_index = {hi, lo}; // R3 R5
   endfunction

   // word-aligned address decode shared by read and write paths
   function automatic rxeq_reg_e reg_decode(input logic [ADDR_W-1:0] a);
      logic [7:0] ofs;
      ofs = a[7:0];
      reg_decode = REG_NONE;
      if ((a >> 8) == '0) begin
         case (ofs)
            OFS_CTRL:    reg_decode = REG_CTRL;
            OFS_CONN_A:  reg_decode = REG_CONN_A;
            OFS_CONN_B:  reg_decode = REG_CONN_B;
            OFS_HOST_A:  reg_decode = REG_HOST_A;
            OFS_HOST_B:  reg_decode = REG_HOST_B;
            OFS_LONG_A:  reg_decode = REG_LONG_A;
            OFS_LONG_B:  reg_decode = REG_LONG_B;
            OFS_STATUS:  reg_decode = REG_STATUS;
            OFS_APPLIED: reg_decode = REG_APPLIED;
            default:     reg_decode = REG_NONE;
         endcase
      end
   endfunction

   assign pins_raw = {EN, CONN_INSERT, CONN_A_CHAN_LONG, CONN_B_CHAN_LONG,
                      CONN_EQ_STRAP_HI, CONN_EQ_STRAP_LO, HOST_EQ_STRAP_HI, HOST_EQ_STRAP_LO};

   rxeq_sync3 #(
      .W (12)
   ) u_pin_sync (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .d     (pins_raw),
      .q     (pins_q)
   );

   assign en_q     = pins_q[11];
   assign ins_q    = pins_q[10];
   assign long_a_q = pins_q[9];
   assign long_b_q = pins_q[8];
   assign c_hi_q   = pins_q[7:6];
   assign c_lo_q   = pins_q[5:4];
   assign h_hi_q   = pins_q[3:2];
   assign h_lo_q   = pins_q[1:0];

   assign en_rise      = en_q && !top_r.en_d;
   assign adapt_active = en_q && top_r.captured;
   // straps only give fixed eq on the connector side
   assign conn_mode = top_r.cfg_src ? top_r.cmode : CMODE_FIXED; // R10
   assign short_a   = top_r.cfg_src ? top_r.reg_ca : top_r.strap_conn; // R7
   assign short_b   = top_r.cfg_src ? top_r.reg_cb : top_r.strap_conn; // R7

   rxeq_adapt #(
      .FAST_CYC  (FAST_CYC),
      .DWELL_CYC (DWELL_CYC)
   ) u_adapt_a (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .active    (adapt_active),
      .mode      (conn_mode),
      .short_idx (short_a),
      .long_idx  (top_r.long_a),
      .insert    (ins_q),
      .chan_long (long_a_q),
      .eye_score (CONN_A_EYE_SCORE),
      .idx       (ad_idx_a),
      .busy      (ad_busy_a)
   );

   rxeq_adapt #(
      .FAST_CYC  (FAST_CYC),
      .DWELL_CYC (DWELL_CYC)
   ) u_adapt_b (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .active    (adapt_active),
      .mode      (conn_mode),
      .short_idx (short_b),
      .long_idx  (top_r.long_b),
      .insert    (ins_q),
      .chan_long (long_b_q),
      .eye_score (CONN_B_EYE_SCORE),
      .idx       (ad_idx_b),
      .busy      (ad_busy_b)
   );

   assign setup_ph  = PSEL && !PENABLE;
   assign access_ph = PSEL && PENABLE && top_r.pready;
   assign sel       = reg_decode(PADDR);

   always_comb begin
      rd_word = RDATA_RST;
      case (sel)
         REG_CTRL: begin
            rd_word[CTRL_SRC_POS]                 = top_r.cfg_src;
            rd_word[CTRL_MODE_POS +: 2]           = top_r.cmode;
         end
         REG_CONN_A:  rd_word[3:0] = top_r.reg_ca;
         REG_CONN_B:  rd_word[3:0] = top_r.reg_cb;
         REG_HOST_A:  rd_word[3:0] = top_r.reg_ha;
         REG_HOST_B:  rd_word[3:0] = top_r.reg_hb;
         REG_LONG_A:  rd_word[3:0] = top_r.long_a;
         REG_LONG_B:  rd_word[3:0] = top_r.long_b;
         REG_STATUS: begin
            rd_word[3:0]  = top_r.strap_conn;
            rd_word[7:4]  = top_r.strap_host;
            rd_word[8]    = top_r.captured;
            rd_word[9]    = top_r.pull_en;
            rd_word[10]   = ad_busy_a;
            rd_word[11]   = ad_busy_b;
         end
         REG_APPLIED: begin
            rd_word[15:0] = {top_r.out_hb, top_r.out_ha, top_r.out_cb, top_r.out_ca};
         end
         default: begin
            rd_word = RDATA_RST;
         end
      endcase
   end

   always_comb begin
      top_nxt      = top_r;
      top_nxt.en_d = en_q;

      // apb: zero wait states, answer registered in setup
      top_nxt.pready  = setup_ph;
      top_nxt.pslverr = setup_ph && (sel == REG_NONE);
      top_nxt.prdata  = (setup_ph && !PWRITE) ? rd_word : RDATA_RST;
      if (access_ph && PWRITE) begin
         case (sel)
            REG_CTRL: begin
               top_nxt.cfg_src = PWDATA[CTRL_SRC_POS];
               top_nxt.cmode   = rxeq_cmode_e'(PWDATA[CTRL_MODE_POS +: 2]); // R10
            end
            REG_CONN_A:  top_nxt.reg_ca = PWDATA[3:0]; // R8
            REG_CONN_B:  top_nxt.reg_cb = PWDATA[3:0]; // R8
            REG_HOST_A:  top_nxt.reg_ha = PWDATA[3:0]; // R8
            REG_HOST_B:  top_nxt.reg_hb = PWDATA[3:0]; // R8
            REG_LONG_A:  top_nxt.long_a = PWDATA[3:0];
            REG_LONG_B:  top_nxt.long_b = PWDATA[3:0];
            default: begin
               top_nxt.cfg_src = top_r.cfg_src;
            end
         endcase
      end

      // strap latch on enable rise only
      if (en_rise) begin
         top_nxt.strap_conn = strap_index(c_hi_q, c_lo_q); // R1 R4 R6 R18
         top_nxt.strap_host = strap_index(h_hi_q, h_lo_q); // R1 R4 R6 R18
         top_nxt.captured   = 1'b1;
      end else if (!en_q) begin
         top_nxt.captured   = 1'b0;
      end

      // pull networks on while enable low, off once sampled
      if (!en_q) begin
         top_nxt.pull_en = 1'b1;
      end else if (top_r.captured) begin
         top_nxt.pull_en = 1'b0; // R2
      end

      top_nxt.out_ca = ad_idx_a; // R7 R11
      top_nxt.out_cb = ad_idx_b; // R7 R11
      // host side has no adaptive path
      top_nxt.out_ha = top_r.cfg_src ? top_r.reg_ha : top_r.strap_host; // R9 R7
      top_nxt.out_hb = top_r.cfg_src ? top_r.reg_hb : top_r.strap_host; // R9 R7
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         top_r            <= '0;
         top_r.prdata     <= RDATA_RST;
         top_r.cfg_src    <= SRC_RST;
         top_r.cmode      <= CMODE_RST;
         top_r.reg_ca     <= IDX_RST;
         top_r.reg_cb     <= IDX_RST;
         top_r.reg_ha     <= IDX_RST;
         top_r.reg_hb     <= IDX_RST;
         top_r.long_a     <= IDX_RST;
         top_r.long_b     <= IDX_RST;
         top_r.strap_conn <= IDX_RST;
         top_r.strap_host <= IDX_RST;
         top_r.pull_en    <= PULL_RST;
      end else begin
         top_r <= top_nxt;
      end
   end

   assign PRDATA               = top_r.prdata;
   assign PREADY               = top_r.pready;
   assign PSLVERR              = top_r.pslverr;
   assign STRAP_PULL_EN        = top_r.pull_en;
   assign CONN_LANE_A_EQ_INDEX = top_r.out_ca;
   assign CONN_LANE_B_EQ_INDEX = top_r.out_cb;
   assign HOST_LANE_A_EQ_INDEX = top_r.out_ha;
   assign HOST_LANE_B_EQ_INDEX = top_r.out_hb;
endmodule

//--- rxeq_strap_cfg_bench.sv
// testbench for rxeq_strap_cfg: apb tasks, strap capture and eq modes
// assumes board model rxeq_board and bound checker
module rxeq_strap_cfg_bench
   import rxeq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst_n, psel, penable, pwrite, en, ins, long_a, long_b, pready, pslverr, pull_en, err;
   logic [7:0]  paddr, eye_a, eye_b;
   logic [31:0] pwdata, prdata, rd;
   rxeq_lvl_t   ch, cl, hh, hl;
   rxeq_idx_t   ca, cb, ha, hb, conn_set, host_set, peak_a, peak_b;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   rxeq_strap_cfg #(.FAST_CYC(20), .DWELL_CYC(4)) DUT (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .EN(en), .CONN_EQ_STRAP_HI(ch), .CONN_EQ_STRAP_LO(cl),
      .HOST_EQ_STRAP_HI(hh), .HOST_EQ_STRAP_LO(hl), .CONN_INSERT(ins), .CONN_A_CHAN_LONG(long_a),
      .CONN_B_CHAN_LONG(long_b), .CONN_A_EYE_SCORE(eye_a), .CONN_B_EYE_SCORE(eye_b),
      .STRAP_PULL_EN(pull_en), .CONN_LANE_A_EQ_INDEX(ca), .CONN_LANE_B_EQ_INDEX(cb),
      .HOST_LANE_A_EQ_INDEX(ha), .HOST_LANE_B_EQ_INDEX(hb));
   rxeq_board u_board (.clk(clk), .pull_en(pull_en), .conn_set(conn_set), .host_set(host_set),
      .peak_a(peak_a), .peak_b(peak_b), .idx_a(ca), .idx_b(cb), .conn_hi(ch), .conn_lo(cl),
      .host_hi(hh), .host_lo(hl), .eye_a(eye_a), .eye_b(eye_b));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic results();
      if (err_total == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         results();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one apb transfer, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      check(err, 1'b0);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
      check(err, eexp);
   endtask
   task automatic restrap(input rxeq_idx_t c, input rxeq_idx_t h);
      en <= 1'b0;
      conn_set <= c;
      host_set <= h;
      tick(10);
      en <= 1'b1;
      tick(12);
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, en, ins, long_a, long_b} = 8'h00;
      {paddr, pwdata, conn_set, host_set, peak_a, peak_b} = '0;
      tick(4);
      rst_n <= 1'b1;
      tick(1);
      rdchk(OFS_CTRL, 32'h0000_0000, 1'b0);
      rdchk(OFS_STATUS, 32'h0000_0200, 1'b0);
      rdchk(8'h24, 32'h0000_0000, 1'b1);
      rdchk(8'h02, 32'h0000_0000, 1'b1);
      for (int k = 0; k < 16; k++) begin
         restrap(k[3:0], 4'hF - k[3:0]);
         check(ca, k[3:0]);
         check(cb, k[3:0]);
         check(ha, 4'hF - k[3:0]);
         check(hb, 4'hF - k[3:0]);
         check(pull_en, 1'b0);
      end
      rdchk(OFS_STATUS, 32'h0000_010F, 1'b0);
      conn_set <= 4'h5;
      host_set <= 4'h6;
      tick(12);
      check(ca, 4'hF);
      check(ha, 4'h0);
      wr(OFS_CTRL, 32'h0000_0001);
      for (int k = 0; k < 16; k++) begin
         wr(OFS_CONN_A, k);
         wr(OFS_HOST_A, 15 - k);
         tick(4);
         check(ca, k[3:0]);
         check(ha, 4'hF - k[3:0]);
      end
      wr(OFS_CONN_A, 32'h0000_0003);
      wr(OFS_CONN_B, 32'h0000_0009);
      wr(OFS_HOST_A, 32'h0000_0005);
      wr(OFS_HOST_B, 32'h0000_000C);
      wr(OFS_LONG_A, 32'h0000_000E);
      wr(OFS_LONG_B, 32'h0000_0007);
      wr(OFS_APPLIED, 32'hFFFF_FFFF);
      tick(6);
      rdchk(OFS_APPLIED, 32'h0000_C593, 1'b0);
      ins <= 1'b1;
      tick(30);
      check(ca, 4'h3);
      long_a <= 1'b1;
      ins <= 1'b0;
      wr(OFS_CTRL, 32'h0000_0003);
      tick(4);
      ins <= 1'b1;
      tick(40);
      check(ca, 4'hE);
      check(cb, 4'h9);
      check(ha, 4'h5);
      peak_a <= 4'h6;
      peak_b <= 4'hB;
      ins <= 1'b0;
      wr(OFS_CTRL, 32'h0000_0005);
      tick(4);
      ins <= 1'b1;
      tick(100);
      check(ca, 4'h6);
      check(cb, 4'hB);
      check(hb, 4'hC);
      peak_a <= 4'h2;
      ins <= 1'b0;
      tick(6);
      ins <= 1'b1;
      tick(100);
      check(ca, 4'h2);
      wr(OFS_CTRL, 32'h0000_0007);
      tick(6);
      check(ca, 4'h3);
      check(cb, 4'h9);
      wr(OFS_CTRL, 32'h0000_0001);
      tick(6);
      check(ca, 4'h3);
      results();
   end
endmodule

//--- rxeq_strap_cfg_properties.sv
// checker for the eq strap/config block ports
// assumes bind onto rxeq_strap_cfg, one clock domain
module rxeq_chk
   import rxeq_pkg::*;
(
   input wire logic                CLK_SYS,
   input wire logic                RST_N,
   input wire logic                PSEL,
   input wire logic                PENABLE,
   input wire logic                PWRITE,
   input wire logic [31:0]         PRDATA,
   input wire logic                PREADY,
   input wire logic                PSLVERR,
   input wire logic                EN,
   input wire logic                STRAP_PULL_EN,
   input wire rxeq_pkg::rxeq_idx_t HOST_LANE_A_EQ_INDEX,
   input wire rxeq_pkg::rxeq_idx_t HOST_LANE_B_EQ_INDEX
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] quiet_r;
   logic       en_d_r;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   // cycles since the last write or enable change
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         quiet_r <= 5'h00;
         en_d_r  <= 1'b0;
      end else begin
         en_d_r <= EN;
         if ((PSEL && PWRITE) || (EN != en_d_r))
            quiet_r <= 5'h00;
         else if (quiet_r != 5'h1F)
            quiet_r <= quiet_r + 5'h01;
      end
   end
   AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   AST_READY_ONE: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_RDATA_IDLE: assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0000_0000)
      else $error("read data outside read access");
   AST_PULL_RESTORE: assert property (!EN [*6] |=> STRAP_PULL_EN)
      else $error("pulls not restored with enable low");
   AST_PULL_OFF: assert property ($rose(EN) ##1 EN [*8] |=> !STRAP_PULL_EN)
      else $error("pulls still on after capture");
   AST_PULL_FALL_CAUSE: assert property ($fell(STRAP_PULL_EN) |-> EN && $past(EN, 3))
      else $error("pulls dropped without enable rise");
   AST_HOST_STEADY: assert property (quiet_r > 5'h14 |-> $stable(HOST_LANE_A_EQ_INDEX) && $stable(HOST_LANE_B_EQ_INDEX))
      else $error("host index moved without cause");
endmodule

bind rxeq_strap_cfg rxeq_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EN(EN),
   .STRAP_PULL_EN(STRAP_PULL_EN), .HOST_LANE_A_EQ_INDEX(HOST_LANE_A_EQ_INDEX),
   .HOST_LANE_B_EQ_INDEX(HOST_LANE_B_EQ_INDEX));

//--- rxeq_sync3.sv
// three-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk; q changes once stages two and three agree
module rxeq_sync3 #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rxeq_sync_s;

   rxeq_sync_s sync_r;
   rxeq_sync_s sync_nxt;
   logic [W-1:0] differ;

   always_comb begin
      sync_nxt    = sync_r;
      differ      = sync_r.s2 ^ sync_r.s3;
      sync_nxt.s1 = d;
      sync_nxt.s2 = sync_r.s1;
      sync_nxt.s3 = sync_r.s2;
      sync_nxt.q  = (sync_r.q & differ) | (sync_r.s3 & ~differ);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_r <= '0;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign q = sync_r.q;
endmodule
